// [logic/actuation_timing_regs.vh]
// Offsets, field positions, reset value and timing figures for the
// actuation timing and braking configuration block.
// Assumes inclusion by the design files only; definitions, no logic.
`ifndef ACTUATION_TIMING_REGS_VH
`define ACTUATION_TIMING_REGS_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define TIMING_CFG_ADDR     6'h02
`define TIMING_CFG_RESET    16'h0000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EXT2_INHIBIT_BIT    15
`define EXT1_INHIBIT_BIT    14
`define INHIBIT_MSB         15
`define INHIBIT_LSB         8
`define ON_CODE_MSB         7
`define ON_CODE_LSB         3
`define BRAKE_CODE_MSB      2
`define BRAKE_CODE_LSB      1
`define PARITY_BIT          0

// ----------------------------------------------------------------------
// Braking codes
// ----------------------------------------------------------------------
`define BRAKE_NONE          2'h0
`define BRAKE_SHORT         2'h1
`define BRAKE_LONG          2'h2
`define BRAKE_INDEF         2'h3

// ----------------------------------------------------------------------
// Emergency pattern on the two emergency bits
// ----------------------------------------------------------------------
`define EMERGENCY_PATTERN   2'h2

// ----------------------------------------------------------------------
// Timing figures in milliseconds, and the first code of the high range
// ----------------------------------------------------------------------
`define ON_BASE_MS          100
`define ON_STEP_MS          20
`define ON_HIGH_BASE_MS     440
`define ON_HIGH_STEP_MS     40
`define ON_HIGH_CODE        16
`define BRAKE_SHORT_MS      100
`define BRAKE_LONG_MS       200
`define INDEF_LOCKOUT_MS    100

// ----------------------------------------------------------------------
// Clock and millisecond figures
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS       10
`define MS_NS               1000000
`define MS_CYCLES           (`MS_NS / `CLK_PERIOD_NS)
`define MS_COUNT_W          11

`endif

// [logic/ms_tick_counter.v]
// Millisecond counter: divides the clock into 1 ms ticks and counts them.
// Assumes a synchronous active-high reset and a clock enable on clk.
`timescale 1ns/1ps

module ms_tick_counter #(
    parameter CYCLES_PER_MS = 100000
) (
    // Clock, reset, enable
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    // Control
    input  wire        restart,
    // Elapsed whole milliseconds
    output reg  [10:0] ms_count_ff
);

    reg  [31:0] div_ff;
    wire        wrap;

    // ------------------------------------------------------------------
    // Divider and millisecond count
    // ------------------------------------------------------------------
    assign wrap = (div_ff == CYCLES_PER_MS - 1);

    // Restart cycle is the first of the new millisecond, so N ms last
    // exactly N * CYCLES_PER_MS cycles; the count saturates at its top
    always @(posedge clk) begin
        if (rst) begin
            div_ff      <= 32'h0;
            ms_count_ff <= 11'h000;
        end else if (ce) begin
            if (restart) begin
                div_ff      <= 32'h1;
                ms_count_ff <= 11'h000;
            end else if (wrap) begin
                div_ff <= 32'h0;
                if (ms_count_ff != 11'h7FF)
                    ms_count_ff <= ms_count_ff + 11'h001;
            end else begin
                div_ff <= div_ff + 32'h1;
            end
        end
    end

endmodule // ms_tick_counter

// [logic/actuation_timing_brake_config.v]
// Actuation timing and braking configuration register with the on-time
// and dynamic braking sequencer of a multi-output door-lock driver.
// Assumes a frame decoder on clk delivering checked command words, and
// the override, emergency and immediate-actuate bits held elsewhere.
`timescale 1ns/1ps
`include "actuation_timing_regs.vh"

// Operation
// - Commands carry address, data, parity; address 02H selects this register.
// - Register read/write; writes during actuation affect only later actuations.
// - Register contents stay unchanged after an actuation completes.
// - Bits 15..8 inhibit braking: ext2, ext1, internal 6 down to 1.
// - An output with its inhibit flag set is never dynamically braked.
// - Bits 7..3 form the five-bit on-duration code, bit 7 MSB.
// - Codes 0-15: 100+20n ms; codes 16-31: 440+40(n-16) ms.
// - One on-duration applies together to every actuated output.
// - Bits 2..1 form the two-bit braking-duration code, bit 2 MSB.
// - Braking code: 00 none, 01 100ms, 10 200ms, 11 100ms then unlimited.
// - Braking starts in the same cycle the on-phase ends.
// - Braking skips overridden outputs and inhibited outputs.
// - Braking turns on low-side drivers of braked outputs for its duration.
// - Unlimited braking refuses new actuations for its first 100 ms.
// - Host ends unlimited braking by reprogramming and immediate actuation.
// - Emergency entry with immediate-actuate clear ends unlimited braking.
// - Start on enable rise if immediate clear, else on select rise; code takes a select rise only while enable is high.
// - Emergency mode only for emergency bits (1,0); others are normal.
module actuation_timing_brake_config #(
    parameter CYCLES_PER_MS = `MS_CYCLES
) (
    // Clock, reset, enable
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    // Command word from the frame decoder
    input  wire        cmd_valid,
    input  wire        cmd_write,
    input  wire [5:0]  cmd_addr,
    input  wire [15:0] cmd_data,
    input  wire        cmd_parity,
    output reg  [15:0] rd_data_ff,
    output reg         rd_valid_ff,
    output reg         parity_error_ff,
    // Pins from outside the clock domain
    input  wire        chip_select_low_n,
    input  wire        out_enable,
    // Bits held by the external driver command register
    input  wire        immediate_actuate,
    input  wire [1:0]  emergency_select,
    input  wire [7:0]  override_mask,
    // Sequencer outputs
    output reg         on_phase_ff,
    output reg  [7:0]  brake_low_side_ff,
    output reg         brake_indef_ff,
    output reg         start_refused_ff
);

    localparam S_IDLE  = 2'h0;
    localparam S_ON    = 2'h1;
    localparam S_BRAKE = 2'h2;
    localparam S_INDEF = 2'h3;

    reg  [15:0] timing_config_reg_ff;
    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [10:0] on_ms_ff;
    reg  [1:0]  brake_code_ff;
    reg  [7:0]  inhibit_ff;
    reg         cs_sync1_ff;
    reg         cs_sync2_ff;
    reg         cs_prev_ff;
    reg         oe_sync1_ff;
    reg         oe_sync2_ff;
    reg         oe_prev_ff;
    reg         restart;
    wire [10:0] ms_count;
    wire        frame_ok;
    wire        wr_hit;
    wire        rd_hit;
    wire        cs_rise;
    wire        oe_rise;
    wire        start_req;
    wire        emergency;
    wire        emergency_abort;
    wire        lockout;
    wire        start_ok;
    wire [10:0] on_ms_decode;
    wire [10:0] brake_ms;

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    // Odd parity across the address, data bits 15..1 and parity bit
    assign frame_ok = ^{cmd_addr, cmd_data[15:1], cmd_parity};
    assign wr_hit   = cmd_valid & cmd_write & frame_ok &
                      (cmd_addr == `TIMING_CFG_ADDR);
    assign rd_hit   = cmd_valid & ~cmd_write & frame_ok &
                      (cmd_addr == `TIMING_CFG_ADDR);

    // Configuration register; the sequencer never writes it back
    always @(posedge clk) begin
        if (rst) begin
            timing_config_reg_ff <= `TIMING_CFG_RESET;
        end else if (ce) begin
            if (wr_hit)
                timing_config_reg_ff <= {cmd_data[15:1], 1'b0};
        end
    end

    // Read data and frame status, registered
    always @(posedge clk) begin
        if (rst) begin
            rd_data_ff      <= 16'h0000;
            rd_valid_ff     <= 1'b0;
            parity_error_ff <= 1'b0;
        end else if (ce) begin
            rd_valid_ff     <= rd_hit;
            parity_error_ff <= cmd_valid & ~frame_ok;
            if (rd_hit)
                rd_data_ff <= timing_config_reg_ff;
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ------------------------------------------------------------------
    // Two synchroniser flops and one edge flop per pin; edges are taken from the second stage only
    always @(posedge clk) begin
        if (rst) begin
            cs_sync1_ff <= 1'b1;
            cs_sync2_ff <= 1'b1;
            cs_prev_ff  <= 1'b1;
            oe_sync1_ff <= 1'b0;
            oe_sync2_ff <= 1'b0;
            oe_prev_ff  <= 1'b0;
        end else if (ce) begin
            cs_sync1_ff <= chip_select_low_n;
            cs_sync2_ff <= cs_sync1_ff;
            cs_prev_ff  <= cs_sync2_ff;
            oe_sync1_ff <= out_enable;
            oe_sync2_ff <= oe_sync1_ff;
            oe_prev_ff  <= oe_sync2_ff;
        end
    end

    assign cs_rise = cs_sync2_ff & ~cs_prev_ff;
    assign oe_rise = oe_sync2_ff & ~oe_prev_ff;

    // ------------------------------------------------------------------
    // Start, emergency and lockout conditions
    // ------------------------------------------------------------------
    assign start_req = (oe_rise & ~immediate_actuate) |
                       (cs_rise & immediate_actuate & oe_sync2_ff);
    assign emergency = (emergency_select == `EMERGENCY_PATTERN);
    // Select rise in emergency with immediate clear halts timed work
    assign emergency_abort = cs_rise & emergency & ~immediate_actuate;
    // First part of unlimited braking may not be cut short by a new start
    assign lockout = (state_ff == S_INDEF) &
                     (ms_count < `INDEF_LOCKOUT_MS);
    // Normal mode takes a start only when idle or past the lockout;
    // emergency mode takes one over a running actuation
    assign start_ok = start_req & ~lockout &
                      ((state_ff == S_IDLE) | (state_ff == S_INDEF) |
                       emergency);

    // ------------------------------------------------------------------
    // Duration decode
    // ------------------------------------------------------------------
    // On-time from the code in the register at the start instant
    function [10:0] on_time_ms;
        input [4:0] code;
        reg   [31:0] ms_full;
        begin
            if (code < `ON_HIGH_CODE)
                ms_full = `ON_BASE_MS + `ON_STEP_MS * code;
            else
                ms_full = `ON_HIGH_BASE_MS +
                          `ON_HIGH_STEP_MS *
                          (code - `ON_HIGH_CODE);
            // Largest value is 1040, so eleven bits hold every code
            on_time_ms = ms_full[10:0];
        end
    endfunction

    assign on_ms_decode = on_time_ms(
        timing_config_reg_ff[`ON_CODE_MSB:`ON_CODE_LSB]);

    // Timed braking length; unlimited braking times its lockout instead
    assign brake_ms = (brake_code_ff == `BRAKE_LONG) ?
                      11'd`BRAKE_LONG_MS : 11'd`BRAKE_SHORT_MS;

    // ------------------------------------------------------------------
    // Millisecond timer
    // ------------------------------------------------------------------
    ms_tick_counter #(
        .CYCLES_PER_MS (CYCLES_PER_MS)
    ) u_ms_timer (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .restart     (restart),
        .ms_count_ff (ms_count)
    );

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    always @* begin
        nxt_state = state_ff;
        restart   = 1'b0;
        if (emergency_abort) begin
            nxt_state = S_IDLE;
            restart   = 1'b1;
        end else if (start_ok) begin
            nxt_state = S_ON;
            restart   = 1'b1;
        end else begin
            case (state_ff)
                S_IDLE: begin
                    nxt_state = S_IDLE;
                end
                S_ON: begin
                    if (ms_count >= on_ms_ff) begin
                        restart = 1'b1;
                        if (brake_code_ff == `BRAKE_NONE)
                            nxt_state = S_IDLE;
                        else if (brake_code_ff == `BRAKE_INDEF)
                            nxt_state = S_INDEF;
                        else
                            nxt_state = S_BRAKE;
                    end
                end
                S_BRAKE: begin
                    if (ms_count >= brake_ms)
                        nxt_state = S_IDLE;
                end
                S_INDEF: begin
                    nxt_state = S_INDEF;
                end
                default: begin
                    nxt_state = S_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Sequencer state and settings taken at start
    // ------------------------------------------------------------------
    // Settings copy at an accepted start, so later writes wait
    always @(posedge clk) begin
        if (rst) begin
            state_ff      <= S_IDLE;
            on_ms_ff      <= 11'd`ON_BASE_MS;
            brake_code_ff <= `BRAKE_NONE;
            inhibit_ff    <= 8'h00;
        end else if (ce) begin
            state_ff <= nxt_state;
            if (start_ok & ~emergency_abort) begin
                on_ms_ff      <= on_ms_decode;
                brake_code_ff <= timing_config_reg_ff[
                    `BRAKE_CODE_MSB:`BRAKE_CODE_LSB];
                inhibit_ff    <= timing_config_reg_ff[
                    `INHIBIT_MSB:`INHIBIT_LSB];
            end
        end
    end

    // ------------------------------------------------------------------
    // Drive outputs
    // ------------------------------------------------------------------
    // On-phase and low-side braking drive switch on the same edge
    always @(posedge clk) begin
        if (rst) begin
            on_phase_ff       <= 1'b0;
            brake_low_side_ff <= 8'h00;
            brake_indef_ff    <= 1'b0;
            start_refused_ff  <= 1'b0;
        end else if (ce) begin
            on_phase_ff <= (nxt_state == S_ON);
            if ((nxt_state == S_BRAKE) || (nxt_state == S_INDEF))
                brake_low_side_ff <= ~inhibit_ff &
                                     ~override_mask;
            else
                brake_low_side_ff <= 8'h00;
            brake_indef_ff   <= (nxt_state == S_INDEF);
            start_refused_ff <= start_req & ~start_ok &
                                ~emergency_abort;
        end
    end

endmodule // actuation_timing_brake_config

// [bench/actuation_timing_brake_config_props.sv]
// Port checker for the actuation timing and braking block.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
module actuation_timing_brake_config_props #(
    parameter CYCLES_PER_MS = 100000
) (
    // Clock, reset, enable
    input wire        clk,
    input wire        rst,
    input wire        ce,
    // Command port
    input wire        cmd_valid,
    input wire        cmd_write,
    input wire [5:0]  cmd_addr,
    input wire [15:0] cmd_data,
    input wire        cmd_parity,
    input wire [15:0] rd_data_ff,
    input wire        rd_valid_ff,
    input wire        parity_error_ff,
    // Pins and held command bits
    input wire        chip_select_low_n,
    input wire        out_enable,
    input wire        immediate_actuate,
    input wire [1:0]  emergency_select,
    input wire [7:0]  override_mask,
    // Sequencer outputs
    input wire        on_phase_ff,
    input wire [7:0]  brake_low_side_ff,
    input wire        brake_indef_ff,
    input wire        start_refused_ff
);
    localparam STEP = 20 * CYCLES_PER_MS;
    localparam ON_MIN = 100 * CYCLES_PER_MS;
    localparam ON_MAX = 1040 * CYCLES_PER_MS;
    localparam LOCK = 100 * CYCLES_PER_MS - 1;
    reg  [31:0] on_cnt_ff;
    reg  [31:0] brk_cnt_ff;
    wire        good = ^{cmd_addr, cmd_data[15:1], cmd_parity};
    wire        braking = |brake_low_side_ff;
    wire        rd_req = ce & cmd_valid & ~cmd_write & good
                       & (cmd_addr == 6'h02);
    wire        bad_req = ce & cmd_valid & ~good;

    // Length of the current on-phase and braking phase in cycles
    always @(posedge clk) begin
        on_cnt_ff <= (on_phase_ff & ~rst) ? on_cnt_ff + 32'h1 : 32'h0;
        brk_cnt_ff <= ((braking | brake_indef_ff) & ~rst) ?
                      brk_cnt_ff + 32'h1 : 32'h0;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_read_answer: assert property (rd_req |=> rd_valid_ff)
        else $error("read not answered");
    a_parity_refused:
    assert property (bad_req |=> parity_error_ff && !rd_valid_ff)
        else $error("bad parity not refused");
    a_brake_start: assert property ($rose(braking) |-> $fell(on_phase_ff))
        else $error("braking not at on-phase end");
    a_override_kept:
    assert property ((brake_low_side_ff & $past(override_mask)) == 8'h00)
        else $error("overridden output braked");
    a_on_length:
    assert property ($fell(on_phase_ff) |-> on_cnt_ff % STEP == 0
        && on_cnt_ff >= ON_MIN && on_cnt_ff <= ON_MAX)
        else $error("on-phase length off the table");
    a_brake_length:
    assert property ($fell(braking) && !$past(brake_indef_ff)
        |-> brk_cnt_ff == STEP * 5 || brk_cnt_ff == STEP * 10)
        else $error("braking length wrong");
    a_lockout_held:
    assert property ($rose(on_phase_ff) && $past(brake_indef_ff)
        |-> $past(brk_cnt_ff) >= LOCK)
        else $error("start inside braking lockout");
    a_refuse_busy:
    assert property (start_refused_ff |-> $past(on_phase_ff)
        || $past(braking) || $past(brake_indef_ff))
        else $error("start refused while idle");

    // Main scenarios reached
    c_indef: cover property ($rose(brake_indef_ff));
    c_refused: cover property (start_refused_ff);
    c_abort: cover property ($fell(brake_indef_ff) && !on_phase_ff);
endmodule // actuation_timing_brake_config_props

bind actuation_timing_brake_config actuation_timing_brake_config_props #(
    .CYCLES_PER_MS(CYCLES_PER_MS)) chk (
    .clk(clk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_parity(cmd_parity), .rd_data_ff(rd_data_ff),
    .rd_valid_ff(rd_valid_ff), .parity_error_ff(parity_error_ff),
    .chip_select_low_n(chip_select_low_n), .out_enable(out_enable),
    .immediate_actuate(immediate_actuate),
    .emergency_select(emergency_select), .override_mask(override_mask),
    .on_phase_ff(on_phase_ff), .brake_low_side_ff(brake_low_side_ff),
    .brake_indef_ff(brake_indef_ff), .start_refused_ff(start_refused_ff));

// [bench/host_master_model.sv]
// Host controller model: command words and the two actuation pins.
// Assumes the block samples the pins with its own clock.
`timescale 1ns/1ps
module host_master_model (
    // Clock
    input  wire        clk,
    // Command word
    output reg         cmd_valid = 1'b0,
    output reg         cmd_write = 1'b0,
    output reg  [5:0]  cmd_addr = 6'h00,
    output reg  [15:0] cmd_data = 16'h0000,
    output reg         cmd_parity = 1'b0,
    input  wire [15:0] rd_data_ff,
    input  wire        rd_valid_ff,
    // Actuation pins
    output reg         chip_select_low_n = 1'b1,
    output reg         out_enable = 1'b0
);
    localparam LINK_NS = 125;

    // One word; released fields show inverted data, not the old value
    task xfer(input w, input [5:0] a, input [15:0] d, input bad,
              output [15:0] q);
        integer i;
        @(posedge clk) #1 cmd_valid = 1'b1;
        cmd_write = w;
        cmd_addr = a;
        cmd_data = d;
        cmd_parity = ~^{a, d[15:1]} ^ bad;
        @(posedge clk) #1 cmd_valid = 1'b0;
        cmd_addr = ~a;
        cmd_data = ~d;
        for (i = 0; i < 3 && rd_valid_ff !== 1'b1; i = i + 1)
            @(posedge clk) #1;
        q = rd_valid_ff ? rd_data_ff : 16'hXXXX;
    endtask

    // Select frame of four link periods; its rising end may start a run
    task frame;
        @(posedge clk) #1 chip_select_low_n = 1'b0;
        #(4 * LINK_NS) chip_select_low_n = 1'b1;
    endtask

    // Output enable level change
    task en(input v);
        @(posedge clk) #1 out_enable = v;
    endtask
endmodule // host_master_model

// [bench/actuation_timing_brake_config_bench.sv]
// Self-checking bench for the actuation timing and braking block.
// Assumes the host model drives the command port and both pins.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked = samples_checked + 1; \
    if ((g) !== (e)) begin n_errors = n_errors + 1; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module actuation_timing_brake_config_bench;
    reg         clk, rst, ce, immediate_actuate;
    reg  [1:0]  emergency_select;
    reg  [7:0]  override_mask;
    reg  [15:0] q;
    wire        cmd_valid, cmd_write, cmd_parity, rd_valid_ff;
    wire        parity_error_ff, chip_select_low_n, out_enable;
    wire        on_phase_ff, brake_indef_ff, start_refused_ff;
    wire [5:0]  cmd_addr;
    wire [15:0] cmd_data, rd_data_ff;
    wire [7:0]  brake_low_side_ff;
    integer     n_errors, samples_checked, i, n, t0;
    localparam logic [37:0] ROWS [4] = '{
        {6'h02, 16'hFFFF, 16'hFFFE}, {6'h03, 16'h0000, 16'hFFFE},
        {6'h02, 16'h5555, 16'h5554}, {6'h02, 16'hAAAA, 16'hAAAA}};

    // Design with a ten-cycle millisecond, and the host
    actuation_timing_brake_config #(.CYCLES_PER_MS(10)) uut (
        .clk(clk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_parity(cmd_parity), .rd_data_ff(rd_data_ff),
        .rd_valid_ff(rd_valid_ff), .parity_error_ff(parity_error_ff),
        .chip_select_low_n(chip_select_low_n), .out_enable(out_enable),
        .immediate_actuate(immediate_actuate),
        .emergency_select(emergency_select), .override_mask(override_mask),
        .on_phase_ff(on_phase_ff), .brake_low_side_ff(brake_low_side_ff),
        .brake_indef_ff(brake_indef_ff), .start_refused_ff(start_refused_ff));
    host_master_model host (
        .clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_parity(cmd_parity),
        .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
        .chip_select_low_n(chip_select_low_n), .out_enable(out_enable));

    // Flag chosen by number: on-phase, any braking, refusal
    function pick(input integer s);
        pick = s == 0 ? on_phase_ff : s == 1 ? |brake_low_side_ff
             : start_refused_ff;
    endfunction

    // Bounded wait for a flag level; cnt is the cycles it took
    task wait_for(input integer s, input v, input integer lim,
                  output integer cnt);
        cnt = 0;
        while (pick(s) !== v && cnt < lim) @(posedge clk) #1 cnt = cnt + 1;
        if (pick(s) !== v) begin
            `CHK("wait", v, pick(s))
            test_done;
        end
    endtask

    // Counts, verdict and end of run
    task test_done;
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Clock and run-length limit
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_errors = n_errors + 1;
        test_done;
    end

    // Main sequence
    initial begin
        n_errors = 0;
        samples_checked = 0;
        rst = 1'b1;
        ce = 1'b1;
        immediate_actuate = 1'b0;
        emergency_select = 2'b00;
        override_mask = 8'h00;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        host.xfer(1'b0, 6'h02, 16'h0000, 1'b0, q);
        `CHK("reset", 16'h0000, q)
        for (i = 0; i < 4; i = i + 1) begin
            host.xfer(1'b1, ROWS[i][37:32], ROWS[i][31:16], 1'b0, q);
            host.xfer(1'b0, 6'h02, 16'h0000, 1'b0, q);
            `CHK("row", ROWS[i][15:0], q)
        end
        host.xfer(1'b1, 6'h02, 16'h0000, 1'b1, q);
        host.xfer(1'b0, 6'h02, 16'h0000, 1'b0, q);
        `CHK("bad_parity", 16'hAAAA, q)
        $display("test registers done");
        // Timed run on enable rise, rewritten mid-run and a retrigger refused
        host.xfer(1'b1, 6'h02, 16'h810A, 1'b0, q);
        override_mask = 8'h02;
        host.en(1'b1);
        wait_for(0, 1'b1, 20, n);
        t0 = $time;
        host.xfer(1'b1, 6'h02, 16'h0006, 1'b0, q);
        host.en(1'b0);
        repeat (3) @(posedge clk);
        host.en(1'b1);
        wait_for(2, 1'b1, 10, n);
        wait_for(0, 1'b0, 1300, n);
        `CHK("on_len", 1200, ($time - t0) / 10)
        `CHK("brake_map", 8'h7C, brake_low_side_ff)
        wait_for(1, 1'b0, 1100, n);
        `CHK("brake_len", 1000, n)
        host.xfer(1'b0, 6'h02, 16'h0000, 1'b0, q);
        `CHK("kept", 16'h0006, q)
        $display("test timed run done");
        // Unlimited braking from a select rise, lockout, then exit
        override_mask = 8'h00;
        immediate_actuate = 1'b1;
        host.frame;
        wait_for(0, 1'b1, 20, n);
        wait_for(0, 1'b0, 1100, n);
        `CHK("brake_all", 8'hFF, brake_low_side_ff)
        repeat (500) @(posedge clk);
        host.frame;
        wait_for(2, 1'b1, 10, n);
        repeat (600) @(posedge clk);
        #1 immediate_actuate = 1'b0;
        for (i = 1; i < 4; i = i + 1) begin
            emergency_select = i == 2 ? 2'b00 : i[1:0];
            host.frame;
            repeat (4) @(posedge clk);
            #1 `CHK("normal_mode", 1'b1, brake_indef_ff)
        end
        emergency_select = 2'b00;
        host.xfer(1'b1, 6'h02, 16'h0002, 1'b0, q);
        immediate_actuate = 1'b1;
        host.frame;
        wait_for(0, 1'b1, 20, n);
        `CHK("indef_left", 1'b0, brake_indef_ff)
        wait_for(0, 1'b0, 1100, n);
        wait_for(1, 1'b0, 1100, n);
        `CHK("new_brake", 1000, n)
        $display("test unlimited braking done");
        // Emergency entry with immediate clear ends unlimited braking
        host.xfer(1'b1, 6'h02, 16'h0006, 1'b0, q);
        host.frame;
        wait_for(0, 1'b1, 20, n);
        wait_for(0, 1'b0, 1100, n);
        repeat (1100) @(posedge clk);
        #1 immediate_actuate = 1'b0;
        emergency_select = 2'b10;
        host.frame;
        wait_for(1, 1'b0, 10, n);
        `CHK("abort", 2'b00, {brake_indef_ff, on_phase_ff})
        $display("test emergency done");
        // Second reset with the sequencer idle after the abort
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        host.xfer(1'b0, 6'h02, 16'h0000, 1'b0, q);
        `CHK("reset_again", 16'h0000, q)
        $display("test second reset done");
        test_done;
    end
endmodule // actuation_timing_brake_config_bench
